// ==== shared/dst_pkg.sv ====
// Purpose: Shared constants for the converter strobe and test pin block
// Assumes: 40 MHz bus clock, crystal sampled as an ordinary pin input
// Notes: Rates are kept as frequencies; divider counts derive from them
package dst_pkg;
  // Register map
  localparam logic [7:0] DST_CTRL_OFS = 8'h00;
  localparam logic [7:0] DST_STAT_OFS = 8'h04;
  localparam int DST_CTRL_FILT = 0;
  localparam int DST_CTRL_X16 = 1;
  localparam logic [31:0] DST_CTRL_RST = 32'h0000_0003;
  localparam int DST_ST_SLIP = 0;
  localparam int DST_ST_TEST = 1;
  localparam int DST_ST_INTRAM = 2;
  // Widths
  localparam int DST_ADDR_W = 11;
  localparam int DST_SAMPLE_W = 16;
  localparam int DST_ECC_W = 6;
  localparam int DST_CNT_W = 11;
  // Pin synchroniser vector layout
  localparam int DST_PIN_XTAL = 0;
  localparam int DST_PIN_OSC = 1;
  localparam int DST_PIN_TEST = 2;
  localparam int DST_PIN_RAMT = 3;
  localparam int DST_PIN_MODE_SELECT_4 = 4;
  localparam int DST_PIN_WE = 5;
  localparam int DST_PIN_CS = 6;
  localparam int DST_PIN_ADDR = 7;
  localparam int DST_PIN_W = DST_PIN_ADDR + DST_ADDR_W;
  // Frequencies in Hz
  localparam int DST_HCLK_HZ = 40_000_000;
  localparam int DST_TICK_HZ = 8_467_200;
  localparam int DST_XDIV_HZ = 4_233_600;
  localparam int DST_BCK_ON_HZ = 4_233_600;
  localparam int DST_BCK_OFF_HZ = 2_116_800;
  localparam int DST_DW_ON_HZ = 352_800;
  localparam int DST_DW_OFF_HZ = 176_400;
  localparam int DST_WD_ON_HZ = 176_400;
  localparam int DST_WD_OFF_HZ = 88_200;
  localparam int DST_CH_ON_HZ = 88_200;
  localparam int DST_CH_OFF_HZ = 44_100;
  localparam int DST_FR_HZ = 7_350;
  localparam int DST_SLIP_FRAMES = 4;
  // Divider slots
  localparam int DST_NDIV = 6;
  localparam int DST_DV_XDIV = 0;
  localparam int DST_DV_BCK = 1;
  localparam int DST_DV_DW = 2;
  localparam int DST_DV_WD = 3;
  localparam int DST_DV_CH = 4;
  localparam int DST_DV_FR = 5;

  // Half period in 8.4672 MHz ticks for a divider slot
  function automatic logic [DST_CNT_W-1:0] dst_half(input int idx, input logic filt);
    int hz;
    hz = DST_FR_HZ;
    case (idx)
      DST_DV_XDIV: hz = DST_XDIV_HZ;
      DST_DV_BCK: hz = filt ? DST_BCK_ON_HZ : DST_BCK_OFF_HZ;
      DST_DV_DW: hz = filt ? DST_DW_ON_HZ : DST_DW_OFF_HZ;
      DST_DV_WD: hz = filt ? DST_WD_ON_HZ : DST_WD_OFF_HZ;
      DST_DV_CH: hz = filt ? DST_CH_ON_HZ : DST_CH_OFF_HZ;
      default: hz = DST_FR_HZ;
    endcase
    return DST_CNT_W'(DST_TICK_HZ / (2 * hz));
  endfunction
endpackage

// ==== hdl/dst_rate_div.sv ====
// Purpose: Tick-driven square wave divider with selectable half period
// Assumes: tick is a one-cycle pulse at the 8.4672 MHz base rate
// Notes: restart forces low phase so all dividers share one alignment
`timescale 1ns/100ps
`default_nettype none
module dst_rate_div
  import dst_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic tick,
  input wire logic restart,
  input wire logic [DST_CNT_W-1:0] half,
  output logic wave
);
  logic [DST_CNT_W-1:0] cnt_reg, cnt_next;
  logic wave_reg, wave_next;

  // Count ticks, toggle at each half period
  always_comb begin
    cnt_next = cnt_reg;
    wave_next = wave_reg;
    if (restart) begin
      cnt_next = '0;
      wave_next = 1'b0;
    end else if (tick) begin
      if (cnt_reg >= half - DST_CNT_W'(1)) begin
        cnt_next = '0;
        wave_next = ~wave_reg;
      end else begin
        cnt_next = cnt_reg + DST_CNT_W'(1);
      end
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      wave_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      wave_reg <= wave_next;
    end
  end

  assign wave = wave_reg;
endmodule // dst_rate_div
`default_nettype wire

// ==== hdl/dst_top.sv ====
// Purpose: Converter strobes, bit clocks, monitor pins and memory test pins
// Assumes: Pins arrive asynchronous and are synchronised; internal inputs share hclk
// Notes: Register bus is AHB-Lite, zero wait states, always OKAY
// Contract
// - Address pins high impedance normally; bidirectional when both test selects high.
// - Write strobe pin undriven normally; write-enable input during memory test.
// - Chip select pin undriven normally; chip-enable input during memory test.
// - Crystal divided output runs at 4.2336 MHz.
// - Right and left aperture flags mark the channel being presented.
// - Monitor outputs driven only while mode select 4 is low.
// - Word strobe 176.4 kHz filter on, 88.2 kHz off.
// - Channel strobe 88.2 kHz filter on, 44.1 kHz off.
// - Double word strobe 352.8 kHz filter on, 176.4 kHz off.
// - Converter bit clock 4.2336 MHz filter on, 2.1168 MHz off.
// - Crystal frame sync at 7.35 kHz from the crystal only.
// - Playback frame sync follows reproduced disc frame timing.
// - Playback bit clock is oscillator feedback divided by two.
// - Slip flag when buffer drifts beyond plus or minus four frames.
// - Raw frame sync and sync protection state appear on monitors.
// - Internal buffer memory used whenever memory test select is low.
// - Filter on sends audio through filter; off bypasses it.
`timescale 1ns/100ps
`default_nettype none
module dst_top
  import dst_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic crystal_input,
  input wire logic osc_feedback_input,
  input wire logic test_select,
  input wire logic internal_ram_test_select,
  input wire logic mode_select_4,
  input wire logic [DST_ADDR_W-1:0] mem_addr_pins_in,
  output logic [DST_ADDR_W-1:0] mem_addr_pins_out,
  output logic mem_addr_pins_oe_n,
  input wire logic mem_write_strobe_pin_in,
  output logic mem_write_strobe_pin_out,
  output logic mem_write_strobe_pin_oe_n,
  input wire logic mem_chip_select_pin_in,
  output logic mem_chip_select_pin_out,
  output logic mem_chip_select_pin_oe_n,
  input wire logic [DST_ADDR_W-1:0] buf_addr,
  output logic [DST_ADDR_W-1:0] mem_test_addr,
  output logic mem_test_write,
  output logic mem_test_select,
  output logic use_internal_ram,
  input wire logic [DST_SAMPLE_W-1:0] audio_sample,
  input wire logic [DST_SAMPLE_W-1:0] filtered_sample,
  input wire logic [DST_ECC_W-1:0] ecc_flags_in,
  input wire logic playback_frame_in,
  input wire logic raw_frame_sync_in,
  input wire logic sync_protect_in,
  input wire logic buf_frame_written,
  input wire logic buf_frame_read,
  output logic xtal_div_clock_out,
  output logic word_strobe,
  output logic channel_strobe,
  output logic right_aperture_flag,
  output logic left_aperture_flag,
  output logic monitor_oe_n,
  output logic [DST_ECC_W-1:0] ecc_flags,
  output logic xtal_frame_sync,
  output logic playback_frame_sync,
  output logic playback_bit_clock,
  output logic raw_frame_sync,
  output logic sync_protect_state,
  output logic buffer_slip_flag,
  output logic double_word_strobe,
  output logic dac_bit_clock,
  output logic dac_bit_clock_n,
  output logic serial_data
);
  // Pin synchronisers: first stage feeds only the second
  logic [DST_PIN_W-1:0] pin_raw, pin_s1_reg, pin_s2_reg;
  assign pin_raw = {mem_addr_pins_in, mem_chip_select_pin_in, mem_write_strobe_pin_in,
                    mode_select_4, internal_ram_test_select, test_select,
                    osc_feedback_input, crystal_input};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else if (ce) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic test_s, ramt_s, mode_select_4_s, we_s, cs_s, mem_test_active;
  assign test_s = pin_s2_reg[DST_PIN_TEST];
  assign ramt_s = pin_s2_reg[DST_PIN_RAMT];
  assign mode_select_4_s = pin_s2_reg[DST_PIN_MODE_SELECT_4];
  assign we_s = pin_s2_reg[DST_PIN_WE];
  assign cs_s = pin_s2_reg[DST_PIN_CS];
  assign mem_test_active = test_s & ramt_s;

  // Bus slave state
  logic [31:0] ctrl_reg, ctrl_next;
  logic slip_sticky_reg, slip_sticky_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_ofs_reg, wr_ofs_next;
  logic [31:0] rdata_reg, rdata_next;
  logic filt, x16, addr_phase, slip_evt;
  assign filt = ctrl_reg[DST_CTRL_FILT];
  assign x16 = ctrl_reg[DST_CTRL_X16];
  assign addr_phase = hsel & htrans[1] & hready;

  // Address phase capture, data phase write, read data prepared early
  always_comb begin
    ctrl_next = ctrl_reg;
    slip_sticky_next = slip_sticky_reg;
    wr_pend_next = addr_phase & hwrite;
    wr_ofs_next = addr_phase ? haddr[7:0] : wr_ofs_reg;
    rdata_next = rdata_reg;
    if (wr_pend_reg && wr_ofs_reg == DST_CTRL_OFS) begin
      ctrl_next = {30'h0000_0000, hwdata[DST_CTRL_X16], hwdata[DST_CTRL_FILT]};
    end
    if (wr_pend_reg && wr_ofs_reg == DST_STAT_OFS && hwdata[DST_ST_SLIP]) begin
      slip_sticky_next = 1'b0;
    end
    if (slip_evt) begin
      slip_sticky_next = 1'b1;
    end
    if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        DST_CTRL_OFS: rdata_next = ctrl_reg;
        DST_STAT_OFS: rdata_next = {29'h0000_0000, ~ramt_s, mem_test_active,
                                    slip_sticky_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= DST_CTRL_RST;
      slip_sticky_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      slip_sticky_reg <= slip_sticky_next;
      wr_pend_reg <= wr_pend_next;
      wr_ofs_reg <= wr_ofs_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Base tick at 8.4672 MHz from crystal edges, halved for the 16M crystal
  logic xtal_prev_reg, xtal_prev_next, pre_reg, pre_next, tick, restart;
  logic filt_prev_reg, filt_prev_next;
  logic osc_prev_reg, osc_prev_next, playback_bit_clock_reg, playback_bit_clock_next;
  always_comb begin
    xtal_prev_next = pin_s2_reg[DST_PIN_XTAL];
    osc_prev_next = pin_s2_reg[DST_PIN_OSC];
    filt_prev_next = filt;
    pre_next = pre_reg;
    tick = 1'b0;
    if (pin_s2_reg[DST_PIN_XTAL] && !xtal_prev_reg) begin
      pre_next = x16 ? ~pre_reg : 1'b0;
      tick = ~x16 | pre_reg;
    end
    playback_bit_clock_next = playback_bit_clock_reg;
    if (pin_s2_reg[DST_PIN_OSC] && !osc_prev_reg) begin
      playback_bit_clock_next = ~playback_bit_clock_reg;
    end
  end
  assign restart = filt != filt_prev_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_prev_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      filt_prev_reg <= 1'b0;
      pre_reg <= 1'b0;
      playback_bit_clock_reg <= 1'b0;
    end else if (ce) begin
      xtal_prev_reg <= xtal_prev_next;
      osc_prev_reg <= osc_prev_next;
      filt_prev_reg <= filt_prev_next;
      pre_reg <= pre_next;
      playback_bit_clock_reg <= playback_bit_clock_next;
    end
  end

  // All rate outputs divide one common tick; restart realigns them
  logic [DST_NDIV-1:0] wave;
  genvar gi;
  generate
    for (gi = 0; gi < DST_NDIV; gi++) begin : g_div
      dst_rate_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick(tick),
        .restart(restart),
        .half(dst_half(gi, filt)),
        .wave(wave[gi])
      );
    end
  endgenerate

  // Buffer drift tracking in frames
  logic signed [3:0] drift_reg, drift_next;
  logic slip_lvl_reg, slip_lvl_next;
  always_comb begin
    drift_next = drift_reg + 4'(buf_frame_written) - 4'(buf_frame_read);
    // Both sides signed so a negative drift is not read as a large count
    slip_evt = (drift_next > $signed(4'(DST_SLIP_FRAMES))) ||
               (drift_next < -$signed(4'(DST_SLIP_FRAMES)));
    slip_lvl_next = slip_lvl_reg;
    if (buf_frame_read) begin
      slip_lvl_next = 1'b0;
    end
    if (slip_evt) begin
      drift_next = 4'h0;
      slip_lvl_next = 1'b1;
    end
  end

  // Serial audio: load on each channel strobe edge, shift on bit clock fall
  logic [DST_SAMPLE_W-1:0] shift_reg, shift_next;
  logic ch_prev_reg, bck_prev_reg;
  always_comb begin
    shift_next = shift_reg;
    if (wave[DST_DV_CH] != ch_prev_reg) begin
      shift_next = filt ? filtered_sample : audio_sample;
    end else if (!wave[DST_DV_BCK] && bck_prev_reg) begin
      shift_next = {shift_reg[DST_SAMPLE_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drift_reg <= 4'h0;
      slip_lvl_reg <= 1'b0;
      shift_reg <= '0;
      ch_prev_reg <= 1'b0;
      bck_prev_reg <= 1'b0;
    end else if (ce) begin
      drift_reg <= drift_next;
      slip_lvl_reg <= slip_lvl_next;
      shift_reg <= shift_next;
      ch_prev_reg <= wave[DST_DV_CH];
      bck_prev_reg <= wave[DST_DV_BCK];
    end
  end

  // Monitor group, forced low and released while mode select 4 is high
  localparam int MON_W = DST_ECC_W + 10;
  logic [MON_W-1:0] mon_reg, mon_next;
  always_comb begin
    mon_next = {ecc_flags_in, wave[DST_DV_FR], playback_frame_in, playback_bit_clock_reg,
                raw_frame_sync_in, sync_protect_in, slip_lvl_reg, wave[DST_DV_DW],
                wave[DST_DV_BCK], ~wave[DST_DV_BCK], shift_reg[DST_SAMPLE_W-1]};
    if (mode_select_4_s) begin
      mon_next = '0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_reg <= '0;
    end else if (ce) begin
      mon_reg <= mon_next;
    end
  end
  assign monitor_oe_n = mode_select_4_s;
  assign {ecc_flags, xtal_frame_sync, playback_frame_sync, playback_bit_clock,
          raw_frame_sync, sync_protect_state, buffer_slip_flag, double_word_strobe,
          dac_bit_clock, dac_bit_clock_n, serial_data} = mon_reg;

  assign xtal_div_clock_out = wave[DST_DV_XDIV];
  assign word_strobe = wave[DST_DV_WD];
  assign channel_strobe = wave[DST_DV_CH];
  assign left_aperture_flag = wave[DST_DV_CH];
  assign right_aperture_flag = ~wave[DST_DV_CH];

  // Memory test pins: pins drive the buffer address unless chip select takes them
  logic [DST_ADDR_W-1:0] taddr_reg, taddr_next;
  always_comb begin
    taddr_next = taddr_reg;
    if (mem_test_active && cs_s) begin
      taddr_next = pin_s2_reg[DST_PIN_W-1:DST_PIN_ADDR];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taddr_reg <= '0;
    end else if (ce) begin
      taddr_reg <= taddr_next;
    end
  end
  assign mem_addr_pins_oe_n = ~(mem_test_active & ~cs_s);
  assign mem_addr_pins_out = buf_addr;
  assign mem_write_strobe_pin_out = 1'b0;
  assign mem_write_strobe_pin_oe_n = 1'b1;
  assign mem_chip_select_pin_out = 1'b0;
  assign mem_chip_select_pin_oe_n = 1'b1;
  assign mem_test_addr = taddr_reg;
  assign mem_test_select = mem_test_active & cs_s;
  assign mem_test_write = mem_test_active & cs_s & we_s;
  assign use_internal_ram = ~ramt_s;

  // Checks
  AST_ADDR_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
    !mem_test_active |-> mem_addr_pins_oe_n) else $error("Address pins driven outside test");
  AST_WE_IN: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_test_write |-> mem_test_active && we_s && mem_write_strobe_pin_oe_n)
    else $error("Write strobe misused");
  AST_CS_IN: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_chip_select_pin_oe_n && (mem_test_select == (mem_test_active && cs_s)))
    else $error("Chip select misused");
  AST_XDIV_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tick && !restart |=> xtal_div_clock_out != $past(xtal_div_clock_out))
    else $error("Crystal divider missed a tick");
  AST_APERTURE: assert property (@(posedge hclk) disable iff (!hresetn)
    right_aperture_flag != left_aperture_flag) else $error("Aperture flags overlap");
  AST_MON_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mode_select_4_s |-> monitor_oe_n ##1 mon_reg == '0)
    else $error("Monitor driven with select high");
  AST_BCK_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && filt && tick && !restart |=> wave[DST_DV_BCK] != $past(wave[DST_DV_BCK]))
    else $error("Bit clock not at full rate");
  AST_PLAYBACK_BIT_CLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && pin_s2_reg[DST_PIN_OSC] && !osc_prev_reg |=> playback_bit_clock_reg != $past(playback_bit_clock_reg))
    else $error("Playback clock missed an edge");
  AST_SLIP: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && slip_evt |=> slip_lvl_reg && slip_sticky_reg) else $error("Slip not flagged");
  AST_INTRAM: assert property (@(posedge hclk) disable iff (!hresetn)
    !ramt_s |-> use_internal_ram && !mem_test_select) else $error("Internal memory not selected");
endmodule // dst_top
`default_nettype wire

// ==== test/dst_dac_model.sv ====
// Purpose: Converter model that takes serial words from the strobe block
// Assumes: Strobes, bit clock and data are seen on the system clock
// Notes: Keeps the first 16 bits after each channel strobe edge, MSB first
`timescale 1ns/100ps
`default_nettype none
module dst_dac_model (
  input wire logic hclk,
  input wire logic channel_strobe,
  input wire logic dac_bit_clock,
  input wire logic serial_data,
  output logic [15:0] last_word
);
  logic ch_q;
  logic bck_q;
  logic [15:0] shift_q;
  int nbits = 0;
  // Restart on a channel edge, shift on bit clock rises, latch a full word
  always @(posedge hclk) begin
    ch_q <= channel_strobe;
    bck_q <= dac_bit_clock;
    if (channel_strobe !== ch_q) begin
      nbits <= 0;
    end else if (dac_bit_clock && !bck_q && nbits < 16) begin
      shift_q <= {shift_q[14:0], serial_data};
      nbits <= nbits + 1;
      if (nbits == 15) begin
        last_word <= {shift_q[14:0], serial_data};
      end
    end
  end
endmodule // dst_dac_model
`default_nettype wire

// ==== test/tb_dst_top.sv ====
// Purpose: Self-checking bench for the converter strobe and test pin block
// Assumes: Crystal and oscillator pins run free from the board
// Notes: Rates are checked as edge counts against the divided crystal
`timescale 1ns/100ps
`default_nettype none
module tb_dst_top;
  import dst_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic crystal_input, osc_feedback_input, test_select, internal_ram_test_select;
  logic [DST_ADDR_W-1:0] mem_addr_pins_in, mem_addr_pins_out, tb_addr, buf_addr, mem_test_addr;
  logic mem_addr_pins_oe_n, mem_write_strobe_pin_in, mem_write_strobe_pin_out, tb_we;
  logic mem_write_strobe_pin_oe_n, mem_chip_select_pin_in, mem_chip_select_pin_out, tb_cs;
  logic mem_chip_select_pin_oe_n, mem_test_write, mem_test_select, use_internal_ram;
  logic xtal_div_clock_out, word_strobe, channel_strobe, right_aperture_flag, mode_select_4;
  logic left_aperture_flag, monitor_oe_n, xtal_frame_sync, playback_frame_sync;
  logic playback_bit_clock, raw_frame_sync, sync_protect_state, buffer_slip_flag;
  logic double_word_strobe, dac_bit_clock, serial_data, playback_frame_in;
  logic raw_frame_sync_in, sync_protect_in, buf_frame_written, buf_frame_read, p, x;
  logic hresp, dac_bit_clock_n;
  logic [15:0] audio_sample, filtered_sample, dac_word;
  logic [5:0] ecc_flags_in, ecc_flags;
  realtime xhalf = 29.5;
  int miscompares = 0;
  int checks = 0;
  int n, k, c, i, f;
  int on_hz[4] = '{176_400, 88_200, 352_800, 4_233_600};
  int off_hz[4] = '{88_200, 44_100, 176_400, 2_116_800};

  // Pin levels seen by both parties of the memory test pins
  assign mem_addr_pins_in = mem_addr_pins_oe_n ? tb_addr : mem_addr_pins_out;
  assign mem_write_strobe_pin_in = mem_write_strobe_pin_oe_n ? tb_we : mem_write_strobe_pin_out;
  assign mem_chip_select_pin_in = mem_chip_select_pin_oe_n ? tb_cs : mem_chip_select_pin_out;

  dst_top dut_u (
    .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .crystal_input, .osc_feedback_input,
    .test_select, .internal_ram_test_select, .mode_select_4, .mem_addr_pins_in,
    .mem_addr_pins_out, .mem_addr_pins_oe_n, .mem_write_strobe_pin_in,
    .mem_write_strobe_pin_out, .mem_write_strobe_pin_oe_n, .mem_chip_select_pin_in,
    .mem_chip_select_pin_out, .mem_chip_select_pin_oe_n, .buf_addr, .mem_test_addr,
    .mem_test_write, .mem_test_select, .use_internal_ram, .audio_sample, .filtered_sample,
    .ecc_flags_in, .playback_frame_in, .raw_frame_sync_in, .sync_protect_in,
    .buf_frame_written, .buf_frame_read, .xtal_div_clock_out, .word_strobe, .channel_strobe,
    .right_aperture_flag, .left_aperture_flag, .monitor_oe_n, .ecc_flags, .xtal_frame_sync,
    .playback_frame_sync, .playback_bit_clock, .raw_frame_sync, .sync_protect_state,
    .buffer_slip_flag, .double_word_strobe, .dac_bit_clock, .dac_bit_clock_n, .serial_data
  );

  dst_dac_model dac_u (.hclk, .channel_strobe, .dac_bit_clock, .serial_data, .last_word(dac_word));

  // Bus clock, crystal and playback oscillator, all unrelated in phase
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    crystal_input = 1'b0;
    forever #(xhalf) crystal_input = ~crystal_input;
  end
  initial begin
    osc_feedback_input = 1'b0;
    forever #115 osc_feedback_input = ~osc_feedback_input;
  end

  task automatic give_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int m);
    repeat (m) @(posedge hclk);
  endtask

  // One single AHB-Lite transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
    int t;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsize <= 3'b010;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 100);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 100);
    r = hrdata;
  endtask

  task automatic rd32(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic wside, input int m);
    repeat (m) begin
      if (wside) buf_frame_written <= 1'b1;
      else buf_frame_read <= 1'b1;
      @(posedge hclk);
      buf_frame_written <= 1'b0;
      buf_frame_read <= 1'b0;
      @(posedge hclk);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return word_strobe;
      1: return channel_strobe;
      2: return double_word_strobe;
      3: return dac_bit_clock;
      default: return xtal_frame_sync;
    endcase
  endfunction

  // Divided crystal periods within one period of the chosen strobe
  task automatic per(input int s, input int exp);
    n = 0;
    k = 0;
    c = 0;
    p = 1'b1;
    x = 1'b1;
    while (k < 2 && n < 15000) begin
      @(posedge hclk);
      if (k == 1 && xtal_div_clock_out && !x) c++;
      if (pick(s) && !p) k++;
      p = pick(s);
      x = xtal_div_clock_out;
      n++;
    end
    chk(32'(c), 32'(exp));
  endtask

  // Time over 64 periods of the divided crystal output, within one percent
  task automatic rate;
    realtime t0;
    t0 = 0;
    k = 0;
    n = 0;
    x = 1'b1;
    while (k < 65 && n < 2000) begin
      @(posedge hclk);
      if (xtal_div_clock_out && !x) begin
        if (k == 0) t0 = $realtime;
        k++;
      end
      x = xtal_div_clock_out;
      n++;
    end
    chk(32'(($realtime - t0) > 14966 && ($realtime - t0) < 15268), 32'h1);
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    test_select = 1'b0;
    internal_ram_test_select = 1'b0;
    mode_select_4 = 1'b0;
    tb_addr = 11'h0;
    tb_we = 1'b0;
    tb_cs = 1'b0;
    buf_addr = 11'h0;
    audio_sample = 16'h4c71;
    filtered_sample = 16'hb38e;
    {ecc_flags_in, playback_frame_in, raw_frame_sync_in, sync_protect_in} = 9'h0;
    buf_frame_written = 1'b0;
    buf_frame_read = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd32(DST_CTRL_OFS, DST_CTRL_RST);
    rd32(DST_STAT_OFS, 32'h4);
    xfer(1'b1, 32'h08, 32'hffff_ffff, rd);
    rd32(32'h08, 32'h0);
    chk({mem_addr_pins_oe_n, mem_write_strobe_pin_oe_n, mem_chip_select_pin_oe_n}, 3'h7);
    internal_ram_test_select <= 1'b1;
    step(4);
    chk({mem_addr_pins_oe_n, use_internal_ram}, 2'b10);
    test_select <= 1'b1;
    buf_addr <= 11'h5a3;
    step(4);
    chk({mem_addr_pins_oe_n, mem_addr_pins_out}, {1'b0, 11'h5a3});
    chk({mem_write_strobe_pin_oe_n, mem_chip_select_pin_oe_n}, 2'b11);
    rd32(DST_STAT_OFS, 32'h2);
    tb_cs <= 1'b1;
    tb_we <= 1'b1;
    tb_addr <= 11'h2c6;
    step(6);
    chk({mem_addr_pins_oe_n, mem_test_addr, mem_test_select, mem_test_write}, 14'h2b1b);
    tb_cs <= 1'b0;
    tb_we <= 1'b0;
    test_select <= 1'b0;
    internal_ram_test_select <= 1'b0;
    step(4);
    chk({mem_addr_pins_oe_n, use_internal_ram}, 2'b11);
    pulse(1'b1, 4);
    step(3);
    chk(buffer_slip_flag, 1'b0);
    pulse(1'b1, 1);
    step(3);
    chk(buffer_slip_flag, 1'b1);
    pulse(1'b0, 1);
    step(3);
    chk(buffer_slip_flag, 1'b0);
    rd32(DST_STAT_OFS, 32'h5);
    xfer(1'b1, DST_STAT_OFS, 32'h1, rd);
    rd32(DST_STAT_OFS, 32'h4);
    pulse(1'b0, 3);
    step(3);
    chk(buffer_slip_flag, 1'b0);
    pulse(1'b0, 1);
    step(3);
    chk(buffer_slip_flag, 1'b1);
    for (i = 0; i < 2; i++) begin
      {ecc_flags_in, playback_frame_in, raw_frame_sync_in, sync_protect_in} <= i ? 9'h16f : 9'h090;
      step(4);
      chk({ecc_flags, playback_frame_sync, raw_frame_sync, sync_protect_state}, i ? 9'h16f : 9'h090);
    end
    mode_select_4 <= 1'b1;
    step(6);
    chk({monitor_oe_n, ecc_flags, raw_frame_sync, sync_protect_state}, 9'h100);
    mode_select_4 <= 1'b0;
    step(6);
    chk({monitor_oe_n, raw_frame_sync}, 2'b01);
    n = 0;
    k = 0;
    c = 0;
    while (k < 40 && n < 2000) begin
      @(posedge hclk);
      if (osc_feedback_input && !p) k++;
      if (playback_bit_clock && !x) c++;
      p = osc_feedback_input;
      x = playback_bit_clock;
      n++;
    end
    chk(32'(c >= 19 && c <= 21), 32'h1);
    for (f = 1; f >= 0; f--) begin
      xfer(1'b1, DST_CTRL_OFS, 32'h2 | 32'(f), rd);
      step(40);
      for (i = 0; i < 4; i++) begin
        per(i, 4_233_600 / (f ? on_hz[i] : off_hz[i]));
      end
      step(3);
      chk({left_aperture_flag, right_aperture_flag}, {channel_strobe, ~channel_strobe});
      chk({hresp, dac_bit_clock ^ dac_bit_clock_n}, 2'b01);
      chk(dac_word, f ? filtered_sample : audio_sample);
    end
    per(4, 4_233_600 / 7_350);
    rate();
    xhalf = 59.0;
    xfer(1'b1, DST_CTRL_OFS, 32'h1, rd);
    rd32(DST_CTRL_OFS, 32'h1);
    step(40);
    rate();
    give_verdict();
  end

  // Watchdog against a hung wait
  initial begin
    #2_000_000;
    miscompares++;
    give_verdict();
  end
endmodule // tb_dst_top
`default_nettype wire
